// [dcr_pkg.sv]
// Package of constants and types for the DDR3 command-side block.
// Assumes a single 250 MHz command clock and an eight-bank device.
// Notes on behaviour
// R01 - Controller precharges all banks before enabling.
// R02 - Enable: purpose select bit2=1, bits1:0=00.
// R03 - Enabled: every read returns the fixed pattern.
// R04 - Controller waits mode delays before first read.
// R05 - No writes while purpose select bit2 set.
// R06 - Full calibration read: col 00, bit2 0.
// R07 - Pattern starts additive plus CAS latency later.
// R08 - Controller repeats reads until capture optimized.
// R09 - After recovery, controller clears bit2 to exit.
// R10 - Disabled: reads and writes use the array.
// R11 - Controller waits mode delays before activates.
// R12 - Activate opens row until bank precharged.
// R13 - Controller precharges before activating another row; the bench once activates open bank 2 with another row.
// R14 - Precharge closes one or all banks.
// R15 - Controller may access other bank during precharge.
// R16 - Controller activates idle bank before access.
// R17 - Repeat precharge allowed; period from last one.
// R18 - Chop select 0 gives four beats, 1 eight.
// R19 - Chop select never forms part of column.
// R20 - Burst config 00 fixed eight, 01 selectable.
// R21 - Pattern alternates 0,1 from beat zero.
// R22 - Lane bit 0 carries pattern, others copy.
// R23 - Controller issues only reads while enabled; the bench also sends an activate while enabled.
// R24 - Chopped column bit2 picks lower or upper nibble.
// R25 - Two beats per clock: eight take four cycles.
package dcr_pkg;
  // -----------------------------------------------------------------------
  // Geometry and field positions
  // -----------------------------------------------------------------------
  localparam int BANKS     = 8;   // Number of banks.
  localparam int BA_W      = 3;   // Bank select width.
  localparam int ADDR_W    = 13;  // Address input width.
  localparam int COL_W     = 10;  // Column address width.
  localparam int LANE_W    = 16;  // Both byte lanes of one beat.
  localparam int WORD_W    = 32;  // Two beats per clock cycle.
  localparam int AP_BIT    = 10;  // Auto precharge select bit.
  localparam int BC_BIT    = 12;  // Burst chop select bit.
  localparam int PS_EN_BIT = 2;   // Purpose select enable bit.
  localparam int FIFO_DEPTH = 32; // Read data buffer depth.
  // -----------------------------------------------------------------------
  // Mode register selection and field values
  // -----------------------------------------------------------------------
  localparam logic [2:0] MR_BURST   = 3'h0; // Burst config mode register.
  localparam logic [2:0] MR_PURPOSE = 3'h3; // Purpose select mode register.
  localparam logic [1:0] BL_FIXED8  = 2'h0; // Fixed eight-beat bursts.
  localparam logic [1:0] BL_OTF     = 2'h1; // Chop selected per command.
  localparam logic [1:0] PS_LOC_CAL = 2'h0; // Calibration pattern location.
  // Pattern word: even beat all zero, odd beat all one.
  localparam logic [31:0] CAL_WORD  = 32'hffff0000;
  // -----------------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------------
  localparam int TCK_PS  = 4000;  // Clock period in ps.
  localparam int TRP_PS  = 15000; // Precharge period in ps.
  localparam int TRP_CYC = (TRP_PS + TCK_PS - 1) / TCK_PS;
  localparam int BL8_CYC = 4;     // Cycles of a full eight-beat burst.
  localparam int BC4_CYC = 2;     // Cycles of a chopped burst.
  localparam int AL_DEF  = 0;     // Default additive latency.
  localparam int CL_DEF  = 6;     // Default CAS latency.
  // -----------------------------------------------------------------------
  // Commands and states
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR
  } dcr_cmd_t;
  typedef enum logic {ST_IDLE, ST_BURST} dcr_state_t;
endpackage

// [dcr_top.sv]
// Read data buffer and DDR3 bank, mode and read burst logic.
// Commands arrive synchronous to CLK; array data answers ARR_* same cycle.
`timescale 1ns/1ns
`default_nettype none
// -------------------------------------------------------------------------
// Word buffer with valid and ready on both sides.
// -------------------------------------------------------------------------
module dcr_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  output var  logic [W-1:0] out_data,
  output var  logic         out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];          // Word storage.
  logic [AW:0]  wp_q, wp_d;         // Write pointer with wrap bit.
  logic [AW:0]  rp_q, rp_d;         // Read pointer with wrap bit.
  logic         push, pop;
  // Pointers; full when indices match and wrap bits differ.
  always_comb begin
    in_ready  = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
    out_valid = wp_q != rp_q;
    out_data  = mem_q[rp_q[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_d      = wp_q + (AW+1)'(push);
    rp_d      = rp_q + (AW+1)'(pop);
  end
  // Register pointers and write storage.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule // dcr_fifo

// -------------------------------------------------------------------------
// Device command side.
// -------------------------------------------------------------------------
module dcr_top #(
  parameter int ADD_LAT = dcr_pkg::AL_DEF,
  parameter int CAS_LAT = dcr_pkg::CL_DEF
) (
  // Clock and reset.
  input  wire logic                     CLK,
  input  wire logic                     RST_B,
  // Command inputs.
  input  wire dcr_pkg::dcr_cmd_t        CMD,
  input  wire logic [dcr_pkg::BA_W-1:0] BA,
  input  wire logic [dcr_pkg::ADDR_W-1:0] ADDR,
  // Array access.
  input  wire logic [31:0]              ARRAY_RDATA,
  output var  logic [dcr_pkg::BA_W-1:0] ARR_BANK,
  output var  logic [dcr_pkg::ADDR_W-1:0] ARR_ROW,
  output var  logic [dcr_pkg::COL_W-1:0] ARR_COL,
  // Read data stream.
  output var  logic [31:0]              DQ_WORD,
  output var  logic                     DQ_VALID,
  input  wire logic                     DQ_READY,
  output var  logic                     FIFO_READY,
  output var  logic                     OVERFLOW,
  // Status.
  output var  logic                     CAL_MODE,
  output var  logic                     OTF_EN,
  output var  logic [dcr_pkg::BANKS-1:0] BANK_OPEN
);
  localparam int RL = ADD_LAT + CAS_LAT;  // Read latency, at least 2.
  localparam int P  = RL - 1;             // Command delay line stages.
  localparam int RL_CHK = RL;
  localparam logic [1:0] BL8_LAST = 2'(dcr_pkg::BL8_CYC - 1);
  localparam logic [1:0] BC4_LAST = 2'(dcr_pkg::BC4_CYC - 1);
  localparam logic [4:0] TRP_C = 5'(dcr_pkg::TRP_CYC);

  // Saturating decrement of a precharge timer.
  function automatic logic [4:0] dec(input logic [4:0] v);
    dec = (v == 5'h00) ? 5'h00 : v - 5'h01;
  endfunction

  // -----------------------------------------------------------------------
  // Mode registers and bank state
  // -----------------------------------------------------------------------
  logic                       cal_q, cal_d;     // Calibration readout on.
  logic                       otf_q, otf_d;     // Per-command chop on.
  logic [dcr_pkg::BANKS-1:0]  open_q, open_d;   // Row open per bank.
  logic [dcr_pkg::ADDR_W-1:0] row_q [dcr_pkg::BANKS];
  logic [dcr_pkg::ADDR_W-1:0] row_d [dcr_pkg::BANKS];
  logic [4:0]                 pre_q [dcr_pkg::BANKS]; // Precharge timers.
  logic [4:0]                 pre_d [dcr_pkg::BANKS];
  logic                       is_rd;            // Read command this cycle.

  // Decode mode sets, activates and precharges.
  always_comb begin
    cal_d  = cal_q;
    otf_d  = otf_q;
    open_d = open_q;
    row_d  = row_q;
    is_rd  = CMD == dcr_pkg::CMD_RD;
    for (int b = 0; b < dcr_pkg::BANKS; b++) begin
      pre_d[b] = dec(pre_q[b]);
    end
    case (CMD)
      dcr_pkg::CMD_MRS: begin
        if (BA == dcr_pkg::MR_PURPOSE) begin
          // Enable only for the pattern location; bit2 low always exits.
          cal_d = ADDR[dcr_pkg::PS_EN_BIT] &&
                  ADDR[1:0] == dcr_pkg::PS_LOC_CAL; // R03 R10
        end else if (BA == dcr_pkg::MR_BURST) begin
          otf_d = ADDR[1:0] == dcr_pkg::BL_OTF; // R20
        end
      end
      dcr_pkg::CMD_ACT: begin
        // Opens only an idle bank whose precharge period has run out.
        if (!open_q[BA] && pre_q[BA] == 5'h00 && !cal_q) begin
          open_d[BA] = 1'b1; // R12
          row_d[BA]  = ADDR; // R12
        end
      end
      dcr_pkg::CMD_PRE: begin
        // Restarts the timer even on idle or precharging banks.
        for (int b = 0; b < dcr_pkg::BANKS; b++) begin
          if (ADDR[dcr_pkg::AP_BIT] || BA == b[dcr_pkg::BA_W-1:0]) begin
            open_d[b] = 1'b0;  // R14
            pre_d[b]  = TRP_C; // R17
          end
        end
      end
      dcr_pkg::CMD_RD: begin
        // Auto precharge is ignored while calibration readout is on.
        if (ADDR[dcr_pkg::AP_BIT] && !cal_q) begin
          open_d[BA] = 1'b0;
          pre_d[BA]  = TRP_C;
        end
      end
      default: begin
        cal_d = cal_q;
      end
    endcase
  end

  // Register mode and bank state.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cal_q  <= 1'b0;
      otf_q  <= 1'b0;
      open_q <= '0;
      for (int b = 0; b < dcr_pkg::BANKS; b++) begin
        row_q[b] <= '0;
        pre_q[b] <= '0;
      end
    end else begin
      cal_q  <= cal_d;
      otf_q  <= otf_d;
      open_q <= open_d;
      row_q  <= row_d;
      pre_q  <= pre_d;
    end
  end

  // -----------------------------------------------------------------------
  // Read latency delay line
  // -----------------------------------------------------------------------
  logic                      pv_q [P];  // Read pending.
  logic                      pc_q [P];  // Pattern read.
  logic                      ph_q [P];  // Chopped burst.
  logic [dcr_pkg::BA_W-1:0]  pb_q [P];  // Bank.
  logic [dcr_pkg::COL_W-1:0] pk_q [P];  // Start column.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < P; i++) begin
        pv_q[i] <= 1'b0;
        pc_q[i] <= 1'b0;
        ph_q[i] <= 1'b0;
        pb_q[i] <= '0;
        pk_q[i] <= '0;
      end
    end else begin
      pv_q[0] <= is_rd;
      pc_q[0] <= cal_q; // R03
      ph_q[0] <= otf_q && !ADDR[dcr_pkg::BC_BIT]; // R18 R20
      pb_q[0] <= BA;
      // Chop select stays out of the column; bit2 keeps the nibble.
      pk_q[0] <= {ADDR[dcr_pkg::COL_W-1:2], 2'b00}; // R19 R24
      for (int i = 1; i < P; i++) begin
        pv_q[i] <= pv_q[i-1];
        pc_q[i] <= pc_q[i-1];
        ph_q[i] <= ph_q[i-1];
        pb_q[i] <= pb_q[i-1];
        pk_q[i] <= pk_q[i-1];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Burst engine: two beats per cycle into the buffer
  // -----------------------------------------------------------------------
  dcr_pkg::dcr_state_t       st_q, st_d;     // Burst running.
  logic [1:0]                cnt_q, cnt_d;   // Cycles left minus one.
  logic                      bc_q, bc_d;     // Pattern burst.
  logic                      ch_q, ch_d;     // Chopped burst.
  logic                      fst_q, fst_d;   // First cycle of a burst.
  logic [dcr_pkg::BA_W-1:0]  bk_q, bk_d;     // Burst bank.
  logic [dcr_pkg::COL_W-1:0] col_q, col_d;   // Column of the even beat.
  logic                      ovf_q, ovf_d;   // Sticky dropped word.
  logic                      push, in_rdy;
  logic [31:0]               word;

  // Advance or load the burst; a pending read overrides the tail.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q - 2'h1;
    bc_d  = bc_q;
    ch_d  = ch_q;
    bk_d  = bk_q;
    fst_d = 1'b0;
    col_d = {col_q[dcr_pkg::COL_W-1:3], col_q[2:0] + 3'h2}; // R25
    push  = st_q == dcr_pkg::ST_BURST;
    word  = bc_q ? dcr_pkg::CAL_WORD : ARRAY_RDATA; // R21 R22
    ovf_d = ovf_q || (push && !in_rdy);
    case (st_q)
      dcr_pkg::ST_IDLE: st_d = dcr_pkg::ST_IDLE;
      dcr_pkg::ST_BURST: begin
        if (cnt_q == 2'h0) begin
          st_d = dcr_pkg::ST_IDLE;
        end
      end
      default: st_d = dcr_pkg::ST_IDLE;
    endcase
    if (pv_q[P-1]) begin
      st_d  = dcr_pkg::ST_BURST; // R07
      cnt_d = ph_q[P-1] ? BC4_LAST : BL8_LAST; // R18 R25
      bc_d  = pc_q[P-1];
      ch_d  = ph_q[P-1];
      bk_d  = pb_q[P-1];
      col_d = pk_q[P-1];
      fst_d = 1'b1;
    end
  end

  // Register burst state and outputs.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_q  <= dcr_pkg::ST_IDLE;
      cnt_q <= '0;
      bc_q  <= 1'b0;
      ch_q  <= 1'b0;
      fst_q <= 1'b0;
      bk_q  <= '0;
      col_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      bc_q  <= bc_d;
      ch_q  <= ch_d;
      fst_q <= fst_d;
      bk_q  <= bk_d;
      col_q <= col_d;
      ovf_q <= ovf_d;
    end
  end

  // Buffer of read words toward the capture side.
  dcr_fifo #(.W(dcr_pkg::WORD_W), .D(dcr_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst_b     (RST_B),
    .in_data   (word),
    .in_valid  (push),
    .in_ready  (in_rdy),
    .out_data  (DQ_WORD),
    .out_valid (DQ_VALID),
    .out_ready (DQ_READY)
  );

  // Outputs from flip-flops; ARR_ROW is selected by bk_q and FIFO_READY is decoded from the buffer pointers.
  always_comb begin
    ARR_BANK   = bk_q;
    ARR_ROW    = row_q[bk_q];
    ARR_COL    = col_q;
    FIFO_READY = in_rdy;
    OVERFLOW   = ovf_q;
    CAL_MODE   = cal_q;
    OTF_EN     = otf_q;
    BANK_OPEN  = open_q;
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  cal_enter_a: assert property (CMD == dcr_pkg::CMD_MRS &&
    BA == dcr_pkg::MR_PURPOSE && ADDR[2:0] == 3'h4 |=> CAL_MODE) // R03
    else $error("calibration mode not entered");
  cal_exit_a: assert property (CMD == dcr_pkg::CMD_MRS &&
    BA == dcr_pkg::MR_PURPOSE && !ADDR[2] |=> !CAL_MODE) // R10
    else $error("calibration mode not left");
  act_open_a: assert property (CMD == dcr_pkg::CMD_ACT && !cal_q &&
    !open_q[BA] && pre_q[BA] == 5'h00 |=> BANK_OPEN[$past(BA)] &&
    row_q[$past(BA)] == $past(ADDR)) // R12
    else $error("activate did not open row");
  pre_time_a: assert property (CMD == dcr_pkg::CMD_PRE |=>
    !BANK_OPEN[$past(BA)] && pre_q[$past(BA)] == TRP_C) // R14 R17
    else $error("precharge timer not restarted");
  rd_lat_a: assert property (is_rd |-> ##RL_CHK push && fst_q) // R07
    else $error("read data not at read latency");
  bl8_len_a: assert property (push && fst_q && !ch_q |->
    push [*4]) // R18 R25
    else $error("full burst not four cycles");
  bc4_len_a: assert property (push && fst_q && ch_q |->
    ##1 push ##1 (!push || fst_q)) // R18 R25
    else $error("chopped burst not two cycles");
  cal_data_a: assert property (push && bc_q |->
    word == dcr_pkg::CAL_WORD) // R21 R22
    else $error("calibration pattern wrong");
  col_chop_a: assert property (is_rd |=> pk_q[0] ==
    {$past(ADDR[9:2]), 2'b00} && ph_q[0] == ($past(otf_q) &&
    !$past(ADDR[12]))) // R19 R20 R24
    else $error("column or chop decode wrong");
  cal_rd_c: cover property (push && fst_q && bc_q);
  chop_rd_c: cover property (push && fst_q && ch_q);
  act_c: cover property (CMD == dcr_pkg::CMD_ACT ##1 |BANK_OPEN);
endmodule // dcr_top
`default_nettype wire

// [dcr_ctrl_model.sv]
// Behavioural memory controller that sits across from the command block.
// Assumes dcr_pkg is compiled first and that CLK is shared with the block.
`timescale 1ns/1ns
`default_nettype none
module dcr_ctrl_model #(
  parameter int MODE_GAP = 4  // Mode spacing plus update delay, in cycles.
) (
  // Clock.
  input  wire logic                       CLK,
  // Command outputs.
  output var  dcr_pkg::dcr_cmd_t          CMD,
  output var  logic [dcr_pkg::BA_W-1:0]   BA,
  output var  logic [dcr_pkg::ADDR_W-1:0] ADDR,
  // Read data capture.
  input  wire logic [31:0]                DQ_WORD,
  input  wire logic                       DQ_VALID,
  output var  logic                       DQ_READY
);
  // -----------------------------------------------------------------------
  // Captured read words
  // -----------------------------------------------------------------------
  logic [31:0] got[$];  // Words popped from the read buffer, oldest first.

  // Lines start idle; no write is ever issued by this model.
  initial begin
    CMD      = dcr_pkg::CMD_NOP;
    BA       = '0;
    ADDR     = '0;
    DQ_READY = 1'b0;
  end

  // Drives one command for one cycle; released lines show the inverse.
  task automatic send(input dcr_pkg::dcr_cmd_t c, input logic [2:0] b,
                      input logic [12:0] a);
    @(posedge CLK);
    CMD  <= c;
    BA   <= b;
    ADDR <= a;
    @(posedge CLK);
    CMD  <= dcr_pkg::CMD_NOP;
    BA   <= ~b;
    ADDR <= ~a;
    // A mode change is given time to settle before anything follows.
    if (c == dcr_pkg::CMD_MRS) begin
      repeat (MODE_GAP) @(posedge CLK);
    end
  endtask

  // Lets a number of clock edges pass with no command.
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // Sets the pop request at the next edge.
  task automatic set_ready(input logic v);
    @(posedge CLK);
    DQ_READY <= v;
  endtask

  // A word is taken at every edge where valid and ready meet.
  always @(posedge CLK) begin
    if (DQ_VALID === 1'b1 && DQ_READY === 1'b1) begin
      got.push_back(DQ_WORD);
    end
  end
endmodule  // dcr_ctrl_model
`default_nettype wire

// [test_ddr3_calib_read_bank_control.sv]
// Self-checking bench for the command block and its read buffer.
// Assumes dcr_pkg, dcr_top and dcr_ctrl_model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, sn) \
  begin \
    total_checks++; \
    if ((sn) !== (ex)) begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, (ex), (sn)); \
    end \
  end
module test_ddr3_calib_read_bank_control;
  // -----------------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------------
  localparam int RL = dcr_pkg::AL_DEF + dcr_pkg::CL_DEF;  // Read latency.
  logic              CLK;          // 250 MHz command clock.
  logic              RST_B;        // Synchronous reset, active low.
  dcr_pkg::dcr_cmd_t CMD;          // Command from the controller model.
  logic [2:0]        BA;           // Bank or mode register select.
  logic [12:0]       ADDR;         // Row, column and mode field.
  logic [31:0]       ARRAY_RDATA;  // Array word for the shown address.
  logic [2:0]        ARR_BANK;     // Array bank being read.
  logic [12:0]       ARR_ROW;      // Array row being read.
  logic [9:0]        ARR_COL;      // Array column being read.
  logic [31:0]       DQ_WORD;      // Head of the read buffer.
  logic              DQ_VALID;     // Buffer holds a word.
  logic              DQ_READY;     // Pop request.
  logic              FIFO_READY;   // Buffer not full.
  logic              OVERFLOW;     // A word was dropped.
  logic              CAL_MODE;     // Calibration readout on.
  logic              OTF_EN;       // Chop chosen per command.
  logic [7:0]        BANK_OPEN;    // Open row per bank.
  int                bad_count;    // Mismatches seen.
  int                total_checks; // Comparisons made.

  // The array answers with its own address, so each word names its source.
  assign ARRAY_RDATA = {ARR_COL, ARR_ROW, ~ARR_COL[5:0], ARR_BANK};

  dcr_top dut_u (.CLK(CLK), .RST_B(RST_B), .CMD(CMD), .BA(BA), .ADDR(ADDR),
    .ARRAY_RDATA(ARRAY_RDATA), .ARR_BANK(ARR_BANK), .ARR_ROW(ARR_ROW),
    .ARR_COL(ARR_COL), .DQ_WORD(DQ_WORD), .DQ_VALID(DQ_VALID),
    .DQ_READY(DQ_READY), .FIFO_READY(FIFO_READY), .OVERFLOW(OVERFLOW),
    .CAL_MODE(CAL_MODE), .OTF_EN(OTF_EN), .BANK_OPEN(BANK_OPEN));

  dcr_ctrl_model ctrl_u (.CLK(CLK), .CMD(CMD), .BA(BA), .ADDR(ADDR),
    .DQ_WORD(DQ_WORD), .DQ_VALID(DQ_VALID), .DQ_READY(DQ_READY));

  // Clock with a 4 ns period.
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // -----------------------------------------------------------------------
  // Shared helpers
  // -----------------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Issues a read with pop enabled and judges latency, count and words.
  task automatic read_chk(input logic [12:0] a, input int n, input logic cal,
                          input logic [2:0] b, input logic [12:0] row);
    int          k;
    logic [31:0] w;
    logic [31:0] s;
    logic [9:0]  col;
    k = 0;
    ctrl_u.send(dcr_pkg::CMD_RD, b, a);
    while (ctrl_u.got.size() == 0 && k < 40) begin
      @(posedge CLK);
      #1;
      k++;
    end
    `CHK("first word cycle", RL + 1, k)
    repeat (n + 2) @(posedge CLK);
    #1;
    `CHK("word count", n, ctrl_u.got.size())
    for (int i = 0; i < n; i++) begin
      col = {a[9:2], 2'b00} + 10'(2 * i);
      w = cal ? dcr_pkg::CAL_WORD : {col, row, ~col[5:0], b};
      s = ctrl_u.got.pop_front();
      `CHK("read word", w, s)
    end
  endtask

  // -----------------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------------
  // Every status output is clear after reset.
  task automatic t_reset();
    `CHK("cal mode", 1'b0, CAL_MODE)
    `CHK("chop select", 1'b0, OTF_EN)
    `CHK("open banks", 8'h00, BANK_OPEN)
    `CHK("valid", 1'b0, DQ_VALID)
    `CHK("overflow", 1'b0, OVERFLOW)
    $display("test reset done");
  endtask

  // Enter calibration readout, read full and chopped bursts, then leave.
  task automatic t_cal();
    ctrl_u.set_ready(1'b1);
    ctrl_u.send(dcr_pkg::CMD_PRE, 3'h0, 13'h0400);
    ctrl_u.idle(dcr_pkg::TRP_CYC);
    ctrl_u.send(dcr_pkg::CMD_MRS, 3'h0, 13'h0001);
    #1;
    `CHK("chop select", 1'b1, OTF_EN)
    ctrl_u.send(dcr_pkg::CMD_MRS, 3'h3, 13'h0004);
    #1;
    `CHK("cal mode", 1'b1, CAL_MODE)
    ctrl_u.send(dcr_pkg::CMD_ACT, 3'h1, 13'h0011);
    #1;
    `CHK("open banks", 8'h00, BANK_OPEN)
    read_chk(13'h1000, 4, 1'b1, 3'h5, 13'h0000);
    read_chk(13'h1000, 4, 1'b1, 3'h5, 13'h0000);
    read_chk(13'h0004, 2, 1'b1, 3'h2, 13'h0000);
    read_chk(13'h0000, 2, 1'b1, 3'h0, 13'h0000);
    read_chk(13'h1400, 4, 1'b1, 3'h7, 13'h0000);
    ctrl_u.idle(4);
    ctrl_u.send(dcr_pkg::CMD_MRS, 3'h3, 13'h0003);
    #1;
    `CHK("cal mode", 1'b0, CAL_MODE)
    $display("test calibration done");
  endtask

  // Row open and close, reads from the array, repeat precharge timing.
  task automatic t_bank();
    ctrl_u.send(dcr_pkg::CMD_ACT, 3'h2, 13'h0123);
    #1;
    `CHK("open banks", 8'h04, BANK_OPEN)
    read_chk(13'h1010, 4, 1'b0, 3'h2, 13'h0123);
    read_chk(13'h000c, 2, 1'b0, 3'h2, 13'h0123);
    ctrl_u.send(dcr_pkg::CMD_ACT, 3'h2, 13'h0055);
    read_chk(13'h1000, 4, 1'b0, 3'h2, 13'h0123);
    ctrl_u.send(dcr_pkg::CMD_MRS, 3'h0, 13'h0000);
    #1;
    `CHK("chop select", 1'b0, OTF_EN)
    read_chk(13'h0008, 4, 1'b0, 3'h2, 13'h0123);
    ctrl_u.send(dcr_pkg::CMD_PRE, 3'h2, 13'h0000);
    #1;
    `CHK("open banks", 8'h00, BANK_OPEN)
    ctrl_u.send(dcr_pkg::CMD_PRE, 3'h2, 13'h0000);
    ctrl_u.idle(1);
    ctrl_u.send(dcr_pkg::CMD_ACT, 3'h2, 13'h0055);
    #1;
    `CHK("open banks", 8'h00, BANK_OPEN)
    ctrl_u.idle(dcr_pkg::TRP_CYC);
    ctrl_u.send(dcr_pkg::CMD_ACT, 3'h2, 13'h0055);
    ctrl_u.send(dcr_pkg::CMD_ACT, 3'h5, 13'h0077);
    #1;
    `CHK("open banks", 8'h24, BANK_OPEN)
    // Bank 2 precharges while bank 5 is read with auto precharge.
    ctrl_u.send(dcr_pkg::CMD_PRE, 3'h2, 13'h0000);
    read_chk(13'h1400, 4, 1'b0, 3'h5, 13'h0077);
    `CHK("open banks", 8'h00, BANK_OPEN)
    ctrl_u.send(dcr_pkg::CMD_PRE, 3'h0, 13'h0400);
    #1;
    `CHK("open banks", 8'h00, BANK_OPEN)
    $display("test banks done");
  endtask

  // Fill the buffer past full while the reader stalls, then drain it.
  task automatic t_fifo();
    logic [31:0] s;
    ctrl_u.set_ready(1'b0);
    ctrl_u.idle(dcr_pkg::TRP_CYC);
    ctrl_u.send(dcr_pkg::CMD_ACT, 3'h1, 13'h0001);
    for (int i = 0; i < 9; i++) begin
      ctrl_u.send(dcr_pkg::CMD_RD, 3'h1, 13'h1000);
      ctrl_u.idle(2);
    end
    ctrl_u.idle(RL + 8);
    #1;
    `CHK("buffer ready", 1'b0, FIFO_READY)
    `CHK("overflow", 1'b1, OVERFLOW)
    ctrl_u.set_ready(1'b1);
    ctrl_u.idle(dcr_pkg::FIFO_DEPTH + 8);
    #1;
    `CHK("drained words", dcr_pkg::FIFO_DEPTH, ctrl_u.got.size())
    `CHK("valid", 1'b0, DQ_VALID)
    s = ctrl_u.got.pop_front();
    `CHK("first word", {10'h000, 13'h0001, 6'h3f, 3'h1}, s)
    ctrl_u.got.delete();
    $display("test buffer done");
  endtask

  // -----------------------------------------------------------------------
  // Main sequence and watchdog
  // -----------------------------------------------------------------------
  initial begin
    bad_count = 0;
    total_checks = 0;
    RST_B = 1'b0;
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    #1;
    t_reset();
    t_cal();
    t_bank();
    t_fifo();
    conclude();
  end

  // Cuts a hang short; the tests need well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    conclude();
  end
endmodule  // test_ddr3_calib_read_bank_control
`default_nettype wire
